// ---- logic/switch_ctrl_pkg.sv ----
// Constants shared by the link switch control logic
package switch_ctrl_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int REG_COUNT = 6;
   localparam int INPUT_COUNT = 8;

   // Register offsets
   localparam logic [7:0] HS_MODES_OFFSET = 8'h00;
   localparam logic [7:0] AUX_MODES_OFFSET = 8'h01;
   localparam logic [7:0] TERM_PULSE_OFFSET = 8'h02;
   localparam logic [7:0] RX_BOOST_OFFSET = 8'h03;
   localparam logic [7:0] RX_SETTINGS_OFFSET = 8'h04;
   localparam logic [7:0] TX_SETTINGS_OFFSET = 8'h05;
   localparam logic [7:0] STATUS_OFFSET = 8'h06;

   // Register indices of the delayed configuration registers
   localparam int HS_MODES_IDX = 0;
   localparam int AUX_MODES_IDX = 1;
   localparam int TERM_PULSE_IDX = 2;
   localparam int RX_BOOST_IDX = 3;
   localparam int RX_SETTINGS_IDX = 4;
   localparam int TX_SETTINGS_IDX = 5;

   // Field positions
   localparam int SOURCE_SELECT_BIT = 0;
   localparam int SWITCH_ENABLE_BIT = 6;
   localparam int RX_TERM_OFF_BIT = 0;
   localparam int TX_TERM_ON_BIT = 0;
   localparam int TX_CURRENT_BIT = 1;
   localparam int TX_BOOST_LSB = 2;
   localparam int STATUS_HS_APPLIED_BIT = 0;
   localparam int STATUS_HS_BUSY_BIT = 1;
   localparam int STATUS_PULSE_BIT = 2;
   localparam int STATUS_STRAP_BIT = 3;

   // Values after reset
   localparam logic [7:0] HS_MODES_RESET = 8'h40;
   localparam logic [7:0] AUX_MODES_RESET = 8'h40;
   localparam logic [7:0] TERM_PULSE_RESET = 8'h00;
   localparam logic [7:0] RX_BOOST_RESET = 8'h00;
   localparam logic [7:0] RX_SETTINGS_RESET = 8'h00;
   localparam logic [7:0] TX_SETTINGS_RESET = 8'h03;

   // Writable bits of each register
   localparam logic [7:0] MODES_MASK = 8'h41;
   localparam logic [7:0] FULL_MASK = 8'hFF;
   localparam logic [7:0] RX_SETTINGS_MASK = 8'h01;
   localparam logic [7:0] TX_SETTINGS_MASK = 8'h0F;

   // Serial slave address, upper six bits fixed
   localparam logic [5:0] SLAVE_ADDRESS_UPPER = 6'h24;

   // Timing
   localparam longint CLOCK_HZ = 40000000;
   localparam longint TERM_PULSE_MS = 100;
   localparam longint TERM_PULSE_CYCLES = (TERM_PULSE_MS * CLOCK_HZ) / 1000;
   localparam longint UPDATE_DELAY_US = 200;
   localparam longint UPDATE_DELAY_CYCLES = (UPDATE_DELAY_US * CLOCK_HZ) / 1000000;

   function automatic logic [7:0] reset_value(input int idx);
      case (idx)
         HS_MODES_IDX: reset_value = HS_MODES_RESET;
         AUX_MODES_IDX: reset_value = AUX_MODES_RESET;
         TERM_PULSE_IDX: reset_value = TERM_PULSE_RESET;
         RX_BOOST_IDX: reset_value = RX_BOOST_RESET;
         RX_SETTINGS_IDX: reset_value = RX_SETTINGS_RESET;
         default: reset_value = TX_SETTINGS_RESET;
      endcase
   endfunction

   function automatic logic [7:0] write_mask(input int idx);
      case (idx)
         HS_MODES_IDX: write_mask = MODES_MASK;
         AUX_MODES_IDX: write_mask = MODES_MASK;
         RX_SETTINGS_IDX: write_mask = RX_SETTINGS_MASK;
         TX_SETTINGS_IDX: write_mask = TX_SETTINGS_MASK;
         default: write_mask = FULL_MASK;
      endcase
   endfunction

endpackage

// ---- logic/tmds_link_switch_control.sv ----
// Configuration control of a two-to-one video link switch
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmds_link_switch_control #(
   parameter logic [31:0] TERM_PULSE_CYCLES =
      32'(switch_ctrl_pkg::TERM_PULSE_CYCLES),
   parameter logic [31:0] HS_DELAY_CYCLES =
      32'(switch_ctrl_pkg::UPDATE_DELAY_CYCLES),
   parameter logic [31:0] AUX_DELAY_CYCLES =
      32'(switch_ctrl_pkg::UPDATE_DELAY_CYCLES),
   parameter logic [31:0] SETTINGS_DELAY_CYCLES =
      32'(switch_ctrl_pkg::UPDATE_DELAY_CYCLES)
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic addr_strap,
   output logic [6:0] slave_address,
   output logic hs_source_select,
   output logic hs_output_enable,
   output logic aux_source_select,
   output logic aux_switch_enable,
   output logic [7:0] rx_term_connect,
   output logic [7:0] rx_boost_level,
   output logic tx_term_on,
   output logic tx_current_level,
   output logic [1:0] tx_boost_level
);

   localparam int REG_COUNT = switch_ctrl_pkg::REG_COUNT;

   logic [7:0] shadow_q [REG_COUNT];
   logic [7:0] applied [REG_COUNT];
   logic [REG_COUNT-1:0] window_busy;
   logic [REG_COUNT-1:0] reg_write;
   logic [31:0] pulse_count_q;
   logic pulse_active;
   logic hs_select_prev_q;
   logic strap_q;
   logic strap_taken_q;
   logic [7:0] read_d;
   logic [REG_COUNT-1:0] read_hit;

   // Decode of a register address into a one-hot select
   function automatic logic [REG_COUNT-1:0] decode(input logic [7:0] addr);
      logic [REG_COUNT-1:0] hit;
      hit = '0;
      case (addr)
         switch_ctrl_pkg::HS_MODES_OFFSET: hit[switch_ctrl_pkg::HS_MODES_IDX] = 1'b1;
         switch_ctrl_pkg::AUX_MODES_OFFSET: hit[switch_ctrl_pkg::AUX_MODES_IDX] = 1'b1;
         switch_ctrl_pkg::TERM_PULSE_OFFSET: hit[switch_ctrl_pkg::TERM_PULSE_IDX] = 1'b1;
         switch_ctrl_pkg::RX_BOOST_OFFSET: hit[switch_ctrl_pkg::RX_BOOST_IDX] = 1'b1;
         switch_ctrl_pkg::RX_SETTINGS_OFFSET: hit[switch_ctrl_pkg::RX_SETTINGS_IDX] = 1'b1;
         switch_ctrl_pkg::TX_SETTINGS_OFFSET: hit[switch_ctrl_pkg::TX_SETTINGS_IDX] = 1'b1;
         default: hit = '0;
      endcase
      return hit;
   endfunction

   function automatic logic [31:0] delay_for(input int idx);
      if (idx == switch_ctrl_pkg::HS_MODES_IDX) begin
         delay_for = HS_DELAY_CYCLES;
      end else if (idx == switch_ctrl_pkg::AUX_MODES_IDX) begin
         delay_for = AUX_DELAY_CYCLES;
      end else begin
         delay_for = SETTINGS_DELAY_CYCLES;
      end
   endfunction

   assign reg_write = write_strobe ? decode(address) : '0;
   assign read_hit = decode(address);

   // Software copy and delayed physical copy of each register
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            shadow_q[g] <= switch_ctrl_pkg::reset_value(g);
         end else if (reg_write[g]) begin
            shadow_q[g] <= write_data & switch_ctrl_pkg::write_mask(g);
         end
      end

      update_window #(
         .RESET_VALUE(switch_ctrl_pkg::reset_value(g)),
         .DELAY_CYCLES(delay_for(g))
      ) u_window (
         .clock(clock),
         .rstn(rstn),
         .write_strobe(reg_write[g]),
         .write_value(write_data & switch_ctrl_pkg::write_mask(g)),
         .applied_value(applied[g]),
         .busy(window_busy[g])
      );
   end

   // Register read port, data one cycle after the strobe
   always_comb begin
      read_d = 8'h00;
      if (address == switch_ctrl_pkg::STATUS_OFFSET) begin
         read_d[switch_ctrl_pkg::STATUS_HS_APPLIED_BIT] = hs_source_select;
         read_d[switch_ctrl_pkg::STATUS_HS_BUSY_BIT] =
            window_busy[switch_ctrl_pkg::HS_MODES_IDX];
         read_d[switch_ctrl_pkg::STATUS_PULSE_BIT] = pulse_active;
         read_d[switch_ctrl_pkg::STATUS_STRAP_BIT] = strap_q;
      end else begin
         for (int i = 0; i < REG_COUNT; i++) begin
            if (read_hit[i]) begin
               read_d = shadow_q[i];
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         read_data <= 8'h00;
      end else if (read_strobe) begin
         read_data <= read_d;
      end else begin
         read_data <= 8'h00;
      end
   end

   // Strap is caught once, in the first cycle after reset release
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         strap_q <= 1'b0;
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_q <= addr_strap;
         strap_taken_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         slave_address <= {switch_ctrl_pkg::SLAVE_ADDRESS_UPPER, 1'b0};
      end else if (!strap_taken_q) begin
         slave_address <= {switch_ctrl_pkg::SLAVE_ADDRESS_UPPER, addr_strap};
      end
   end

   // One select steers all four channels, a separate aux select the whole aux group
   assign hs_source_select =
      applied[switch_ctrl_pkg::HS_MODES_IDX][switch_ctrl_pkg::SOURCE_SELECT_BIT];
   assign hs_output_enable =
      applied[switch_ctrl_pkg::HS_MODES_IDX][switch_ctrl_pkg::SWITCH_ENABLE_BIT];
   assign aux_source_select =
      applied[switch_ctrl_pkg::AUX_MODES_IDX][switch_ctrl_pkg::SOURCE_SELECT_BIT];
   assign aux_switch_enable =
      applied[switch_ctrl_pkg::AUX_MODES_IDX][switch_ctrl_pkg::SWITCH_ENABLE_BIT];

   // Output driver settings
   assign tx_term_on =
      applied[switch_ctrl_pkg::TX_SETTINGS_IDX][switch_ctrl_pkg::TX_TERM_ON_BIT];
   assign tx_current_level =
      applied[switch_ctrl_pkg::TX_SETTINGS_IDX][switch_ctrl_pkg::TX_CURRENT_BIT];
   assign tx_boost_level =
      applied[switch_ctrl_pkg::TX_SETTINGS_IDX][switch_ctrl_pkg::TX_BOOST_LSB +: 2];

   // Equalizer: bit set gives the high boost for that input
   assign rx_boost_level = applied[switch_ctrl_pkg::RX_BOOST_IDX];

   // Termination pulse counter, restarted by each change of the high-speed source (hs_source_select only)
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hs_select_prev_q <= 1'b0;
      end else begin
         hs_select_prev_q <= hs_source_select;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pulse_count_q <= 32'h0000_0000;
      end else if (hs_select_prev_q != hs_source_select) begin
         pulse_count_q <= TERM_PULSE_CYCLES;
      end else if (pulse_count_q != 32'h0000_0000) begin
         pulse_count_q <= pulse_count_q - 32'h0000_0001;
      end
   end

   assign pulse_active = (pulse_count_q != 32'h0000_0000);

   // Input terminations: global off, or pulsed off where selected
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_term_connect <= 8'hFF;
      end else if (applied[switch_ctrl_pkg::RX_SETTINGS_IDX][switch_ctrl_pkg::RX_TERM_OFF_BIT]) begin
         rx_term_connect <= 8'h00;
      end else if (pulse_active) begin
         rx_term_connect <= ~applied[switch_ctrl_pkg::TERM_PULSE_IDX];
      end else begin
         rx_term_connect <= 8'hFF;
      end
   end

endmodule
`default_nettype wire

// ---- logic/update_window.sv ----
// Delayed update of one configuration register
`timescale 1ns/1ps
`default_nettype none
module update_window #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [31:0] DELAY_CYCLES = 32'h0000_1F40
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic write_strobe,
   input wire logic [7:0] write_value,
   output logic [7:0] applied_value,
   output logic busy
);

   logic [31:0] count_q;
   logic [7:0] pending_q;
   logic pending_valid_q;
   logic window_end;

   assign window_end = busy && (count_q <= 32'h0000_0001);

   // Window starts at reset, so the first change waits a full delay
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b1;
         count_q <= DELAY_CYCLES;
      end else if (!busy && write_strobe) begin
         busy <= 1'b1;
         count_q <= DELAY_CYCLES;
      end else if (window_end) begin
         busy <= 1'b0;
         count_q <= 32'h0000_0000;
      end else if (busy) begin
         count_q <= count_q - 32'h0000_0001;
      end
   end

   // Last write inside the window is kept for its end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pending_q <= RESET_VALUE;
         pending_valid_q <= 1'b0;
      end else if (window_end) begin
         pending_valid_q <= 1'b0;
      end else if (busy && write_strobe) begin
         pending_q <= write_value;
         pending_valid_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         applied_value <= RESET_VALUE;
      end else if (!busy && write_strobe) begin
         applied_value <= write_value;
      end else if (window_end && write_strobe) begin
         applied_value <= write_value;
      end else if (window_end && pending_valid_q) begin
         applied_value <= pending_q;
      end
   end

endmodule
`default_nettype wire

// ---- tb/link_sink_model.sv ----
// Receiver end that reports which source reaches it
`timescale 1ns/1ps
`default_nettype none
module link_sink_model (
   input wire logic hs_source_select,
   input wire logic hs_output_enable,
   output logic [1:0] seen_source
);
   // External termination is always fitted, so both output states are legal
   always_comb begin
      if (!hs_output_enable) begin
         seen_source = 2'h0;
      end else begin
         seen_source = hs_source_select ? 2'h2 : 2'h1;
      end
   end
endmodule
`default_nettype wire

// ---- tb/switch_ctrl_sva.sv ----
// Port checker for the link switch control block
`timescale 1ns/1ps
`default_nettype none
module switch_ctrl_sva #(
   parameter logic [31:0] TERM_PULSE_CYCLES = 32'h0000_0014,
   parameter logic [31:0] HS_DELAY_CYCLES = 32'h0000_0005
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   input wire logic addr_strap,
   input wire logic [6:0] slave_address,
   input wire logic hs_source_select,
   input wire logic hs_output_enable,
   input wire logic aux_source_select,
   input wire logic aux_switch_enable,
   input wire logic [7:0] rx_term_connect,
   input wire logic tx_term_on,
   input wire logic tx_current_level,
   input wire logic [1:0] tx_boost_level
);
   logic [31:0] hs_cnt_q;
   logic [31:0] quiet_q;
   logic hs_wr;
   logic wd_sel;
   logic wd_en;
   assign hs_wr = write_strobe && address == 8'h00;
   assign wd_sel = write_data[0];
   assign wd_en = write_data[6];
   // Mirror of the high-speed update window
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hs_cnt_q <= HS_DELAY_CYCLES;
      end else if (hs_wr && hs_cnt_q == 32'h0000_0000) begin
         hs_cnt_q <= HS_DELAY_CYCLES;
      end else if (hs_cnt_q != 32'h0000_0000) begin
         hs_cnt_q <= hs_cnt_q - 32'h0000_0001;
      end
   end
   // Cycles since the applied source last changed
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         quiet_q <= 32'hFFFF_FFFF;
      end else if ($changed(hs_source_select)) begin
         quiet_q <= 32'h0000_0000;
      end else if (quiet_q != 32'hFFFF_FFFF) begin
         quiet_q <= quiet_q + 32'h0000_0001;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   addr_upper_a: assert property (slave_address[6:1] == 6'h24)
      else $error("slave address upper bits wrong");
   strap_lsb_a: assert property ($rose(rstn) |=> slave_address[0] == $past(addr_strap))
      else $error("slave address strap bit wrong");
   reset_defaults_a: assert property ($rose(rstn) |-> !hs_source_select && hs_output_enable
      && !aux_source_select && aux_switch_enable && rx_term_connect == 8'hFF && tx_term_on
      && tx_current_level && tx_boost_level == 2'h0) else $error("defaults after reset wrong");
   read_idle_a: assert property (!$past(read_strobe) |-> read_data == 8'h00)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property (read_strobe && address > 8'h06 |=> read_data == 8'h00)
      else $error("unmapped read not zero");
   hs_apply_a: assert property (hs_wr && hs_cnt_q == 32'h0000_0000 |=>
      hs_source_select == $past(wd_sel) && hs_output_enable == $past(wd_en))
      else $error("idle write not applied");
   hs_hold_a: assert property (hs_cnt_q > 32'h0000_0002 |=>
      $stable(hs_source_select) && $stable(hs_output_enable)) else $error("window not held");
   settled_term_a: assert property (quiet_q > TERM_PULSE_CYCLES + 32'h0000_0004 |->
      rx_term_connect == 8'hFF || rx_term_connect == 8'h00)
      else $error("termination pulse not ended");
endmodule
`default_nettype wire

// ---- tb/tmds_link_switch_control_bench.sv ----
// Self-checking bench for the link switch control block
`timescale 1ns/1ps
`default_nettype none
module tmds_link_switch_control_bench;
   localparam logic [31:0] TERM = 32'h0000_0014;
   localparam logic [31:0] DLY = 32'h0000_0005;
   logic clock, rstn, write_strobe, read_strobe, addr_strap;
   logic [7:0] address, write_data, read_data, rx_term_connect, rx_boost_level, d, pmask;
   logic [6:0] slave_address;
   logic hs_source_select, hs_output_enable, aux_source_select, aux_switch_enable;
   logic tx_term_on, tx_current_level;
   logic [1:0] tx_boost_level, seen_source;
   logic [7:0] shadow [0:5];
   int n_fail, checks_done, seed, i, a;

   tmds_link_switch_control #(.TERM_PULSE_CYCLES(TERM), .HS_DELAY_CYCLES(DLY),
      .AUX_DELAY_CYCLES(DLY), .SETTINGS_DELAY_CYCLES(DLY)) dut_u (.clock, .rstn, .address,
      .write_data, .write_strobe, .read_strobe, .read_data, .addr_strap, .slave_address,
      .hs_source_select, .hs_output_enable, .aux_source_select, .aux_switch_enable,
      .rx_term_connect, .rx_boost_level, .tx_term_on, .tx_current_level, .tx_boost_level);
   link_sink_model sink_u (.hs_source_select, .hs_output_enable, .seen_source);

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   function automatic logic [7:0] mask_of(input int idx);
      case (idx)
         0, 1: mask_of = 8'h41;
         4: mask_of = 8'h01;
         5: mask_of = 8'h0F;
         default: mask_of = 8'hFF;
      endcase
   endfunction

   function automatic logic [7:0] rst_of(input int idx);
      case (idx)
         0, 1: rst_of = 8'h40;
         5: rst_of = 8'h03;
         default: rst_of = 8'h00;
      endcase
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge clock);
      address <= ad;
      write_data <= dt;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clock);
      address <= ad;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1;
      check(read_data, exp);
   endtask

   task automatic check_outs();
      check({7'h00, aux_source_select}, {7'h00, shadow[1][0]});
      check({7'h00, aux_switch_enable}, {7'h00, shadow[1][6]});
      check(rx_boost_level, shadow[3]);
      check(rx_term_connect, shadow[4][0] ? 8'h00 : 8'hFF);
      check({4'h0, tx_boost_level, tx_current_level, tx_term_on}, shadow[5]);
      check({6'h00, seen_source}, !shadow[0][6] ? 8'h00 : shadow[0][0] ? 8'h02 : 8'h01);
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge clock);
      n_fail++;
      $display("ERROR %0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      seed = 22;
      n_fail = 0;
      checks_done = 0;
      rstn = 1'b0;
      address = 8'h00;
      write_data = 8'h00;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      addr_strap = 1'b0;
      for (int pass = 0; pass < 2; pass++) begin
         @(posedge clock);
         rstn <= 1'b0;
         addr_strap <= pass[0];
         repeat (16) @(posedge clock);
         for (i = 0; i < 6; i++) shadow[i] = rst_of(i);
         check_outs();
         rstn <= 1'b1;
         repeat (2) @(posedge clock);
         #1;
         check({1'b0, slave_address}, {1'b0, 6'h24, addr_strap});
         for (i = 0; i < 6; i++) rd(i[7:0], shadow[i]);
         rd(8'h07, 8'h00);
         rd(8'hFF, 8'h00);
         $display("reset test done");
         for (i = 0; i < 24; i++) begin
            a = 1 + (($random(seed) & 32'h7FFF_FFFF) % 7);
            d = 8'($random(seed));
            if (a == 5) d[1] = d[0];
            wr(a[7:0], d);
            if (a < 6) shadow[a] = d & mask_of(a);
            if (a != 6) rd(a[7:0], a < 6 ? shadow[a] : 8'h00);
         end
         repeat (10) @(posedge clock);
         check_outs();
         $display("random register test done");
         pmask = 8'($random(seed));
         wr(8'h04, 8'h00);
         wr(8'h02, pmask);
         shadow[4] = 8'h00;
         repeat (10) @(posedge clock);
         wr(8'h00, 8'h41);
         #1;
         check({7'h00, hs_source_select}, 8'h01);
         wr(8'h00, 8'h00);
         #1;
         check({7'h00, hs_source_select}, 8'h01);
         check(rx_term_connect, ~pmask);
         wr(8'h00, 8'h01);
         #1;
         check({7'h00, hs_output_enable}, 8'h01);
         @(posedge clock);
         #1;
         check({6'h00, hs_output_enable, hs_source_select}, 8'h01);
         shadow[0] = 8'h01;
         repeat (TERM + 10) @(posedge clock);
         check_outs();
         rd(8'h06, {4'h0, addr_strap, 3'h1});
         rd(8'h00, 8'h01);
         wr(8'h00, 8'h40);
         $display("switch test done");
      end
      wrap_up();
   end
endmodule

bind tmds_link_switch_control switch_ctrl_sva #(.TERM_PULSE_CYCLES(TERM_PULSE_CYCLES),
   .HS_DELAY_CYCLES(HS_DELAY_CYCLES)) chk_u (.clock, .rstn, .address, .write_data,
   .write_strobe, .read_strobe, .read_data, .addr_strap, .slave_address, .hs_source_select,
   .hs_output_enable, .aux_source_select, .aux_switch_enable, .rx_term_connect, .tx_term_on,
   .tx_current_level, .tx_boost_level);
`default_nettype wire
